/* elo_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ELO_REGS_SVH
`define ELO_REGS_SVH

`define ELO_ADDR_FRONT 6'h01
`define ELO_ADDR_CTRL 6'h02
`define ELO_ADDR_UTH 6'h0a
`define ELO_ADDR_LTH 6'h0b
`define ELO_ADDR_STATUS 6'h1d
`define ELO_ADDR_DCSTAT 6'h1e
`define ELO_ADDR_GAIN0 6'h21
`define ELO_ADDR_GAIN2 6'h23
`define ELO_ADDR_AMP0 6'h31
`define ELO_ADDR_AMP4 6'h35

`define ELO_FRONT_CALDAC 0
`define ELO_FRONT_SHIELD 1
`define ELO_FRONT_RESPCAP 2
`define ELO_FRONT_GAIN_LSB 3
`define ELO_FRONT_GAIN_MSB 4

`define ELO_CTRL_DCEN 0
`define ELO_CTRL_ACEN 1
`define ELO_CTRL_DCCUR_LSB 2
`define ELO_CTRL_DCCUR_MSB 4
`define ELO_CTRL_AMP_LSB 16
`define ELO_CTRL_AMP_MSB 17
`define ELO_CTRL_POL_LSB 18
`define ELO_CTRL_POL_MSB 23

`define ELO_TH_AC_MSB 15
`define ELO_TH_ADC_LSB 16
`define ELO_TH_ADC_MSB 23

`define ELO_GAIN_IDX_LSB 22
`define ELO_GAIN_IDX_MSB 23
`define ELO_GAIN_COEF_MSB 11

`define ELO_DCCUR_RESET 3'h1
`define ELO_UTH_RESET 24'h7f4000
`define ELO_LTH_RESET 24'h800010
`define ELO_COEF_UNITY 12'h800
`define ELO_COEF_SHIFT 11
`define ELO_AMP_SHIFT 8

`define ELO_CLK_HZ 125000000
`define ELO_CARRIER_MHZ 2039000
`define ELO_PHASE_INC 32'((64'd2039000 << 32) / (64'd125000000 * 64'd1000))
`define ELO_AC_DETECT_MS 10
`define ELO_AC_WINDOW_MS 3
`define ELO_AC_WINDOW_CYC ((`ELO_AC_WINDOW_MS * `ELO_CLK_HZ) / 1000)

`endif

/* elo_pkg.sv */
// Types shared by the electrode lead-off monitor
`default_nettype none
package elo_pkg;
    typedef logic signed [23:0] elo_sample_t;

    typedef struct packed {
        logic lead_off;
        logic out_of_range;
    } elo_header_t;

    typedef struct packed {
        logic [2:0] out_of_range;
        logic [3:0] ac_off;
        logic [5:0] dc_off;
    } elo_electrodes_t;

    typedef struct packed {
        logic [13:0] sync1;
        logic [13:0] sync2;
        logic [13:0] sync3;
        logic [13:0] comp;
        logic [4:0] front;
        logic [5:0] pol;
        logic [1:0] ac_amp;
        logic [2:0] dc_cur;
        logic ac_en;
        logic dc_en;
        logic [23:0] uth;
        logic [23:0] lth;
        logic [3:0][2:0][11:0] coef;
        logic nvm_done;
        logic [31:0] phase;
        logic [23:0] win_cnt;
        logic [3:0][31:0] acc_i;
        logic [3:0][31:0] acc_q;
        logic [3:0][15:0] amp;
        logic [3:0] ac_off;
        logic [2:0] oor;
        logic [2:0][23:0] ecg_prev;
        logic [2:0][23:0] ecg_out;
        logic ecg_valid;
        logic [23:0] rdata;
        logic rd_valid;
        logic [5:0] drive;
        logic shield_on;
    } elo_state_t;
endpackage : elo_pkg
`default_nettype wire

/* elo_monitor.sv */
// Electrode lead-off monitor with per-channel gain correction
//
// Contract
// RL1 - Factory gain coefficients load as defaults for gains 0 to 2; gain 3 unity.
// RL2 - Host writes to gain registers replace defaults with volatile user values.
// RL3 - Active gain correction applies to ECG output at every data rate.
// RL4 - AC and DC lead-off are independent, each with its own enable.
// RL5 - Any lead-off event sets the lead-off bit of the frame header.
// RL6 - Off electrode is reported in the frame and in a status register.
// RL7 - DC flag when input passes the fixed upper or lower comparator threshold.
// RL8 - DC injection current programmable 10 to 70 nA in 10 nA steps.
// RL9 - Identical DC detection on all six electrode inputs.
// RL10 - Right-leg drive saturation reported with DC status in register 0x1e.
// RL11 - AC carrier fixed at 2.039 kHz and filtered out of ECG data.
// RL12 - Per-electrode AC polarity at control bits 23:18; amplitude programmable.
// RL13 - AC detection only on the three limb inputs and common-mode input.
// RL14 - AC response I/Q demodulated, amplitude extracted and low-pass filtered.
// RL15 - All AC channels share one upper and one lower threshold.
// RL16 - AC flag when amplitude above upper or below lower threshold.
// RL17 - Per-electrode AC amplitudes readable at 0x31 through 0x35; code maps only 0x31 to 0x34, 0x35 reads zero.
// RL18 - AC lead-off flagged within 10 ms of disconnection.
// RL19 - AC lead-off disabled while the calibration DAC is enabled.
// RL20 - ADC data checked against over/under thresholds; header out-of-range flag.
// RL21 - Shield driver can be disabled; unavailable when pin used for respiration.
// RL22 - Status bits follow the condition and clear once it is gone.
`include "elo_regs.svh"
`default_nettype none
module elo_monitor #(
    parameter int AC_WINDOW_CYC = `ELO_AC_WINDOW_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [5:0] dc_comp_hi,
    input wire logic [5:0] dc_comp_lo,
    input wire logic rld_sat_hi,
    input wire logic rld_sat_lo,
    input wire logic [2:0][2:0][11:0] nvm_coef,
    input wire logic [2:0][23:0] ecg_in,
    input wire logic ecg_in_valid,
    input wire logic [3:0][15:0] ac_in,
    input wire logic ac_in_valid,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata,
    output logic reg_rdata_valid,
    output logic [2:0][23:0] ecg_out,
    output logic ecg_out_valid,
    output elo_pkg::elo_header_t frame_header,
    output elo_pkg::elo_electrodes_t frame_electrodes,
    output logic [5:0] ac_drive,
    output logic [1:0] ac_drive_amp,
    output logic [2:0] dc_current_code,
    output logic dc_inject_en,
    output logic shield_drive_en
);
    import elo_pkg::*;

    elo_state_t s;
    elo_state_t n;
    elo_header_t hdr;
    elo_electrodes_t elec;

    function automatic logic [31:0] abs32(input logic [31:0] v);
        abs32 = v[31] ? 32'(-v) : v;
    endfunction : abs32

    function automatic logic [23:0] gain_fix(input logic [23:0] x,
                                             input logic [11:0] c);
        logic signed [36:0] p;
        p = 37'($signed(x) * $signed({1'b0, c})) >>> `ELO_COEF_SHIFT;
        if (p > 37'sd8388607) begin
            gain_fix = 24'h7fffff;
        end else if (p < -37'sd8388608) begin
            gain_fix = 24'h800000;
        end else begin
            gain_fix = p[23:0];
        end
    endfunction : gain_fix

    function automatic logic [15:0] amp_of(input logic [31:0] i,
                                           input logic [31:0] q);
        logic [32:0] m;
        m = ({1'b0, abs32(i)} + {1'b0, abs32(q)}) >> `ELO_AMP_SHIFT;
        amp_of = (m > 33'h0ffff) ? 16'hffff : m[15:0];
    endfunction : amp_of

    // Live flags feeding header and frame
    always_comb begin
        elec.dc_off = s.dc_en ? (s.comp[5:0] | s.comp[11:6]) : 6'h00; // RL7 RL9
        elec.ac_off = s.ac_off;
        elec.out_of_range = s.oor;
        hdr.lead_off = (|elec.dc_off) | (|s.ac_off)
                       | (s.dc_en & (|s.comp[13:12])); // RL5
        hdr.out_of_range = |s.oor; // RL20
    end

    always_comb begin
        logic ac_active;
        logic win_end;
        logic [1:0] gsel;
        logic [23:0] mix;
        logic [31:0] sx;
        logic [15:0] a;
        int ch;
        ac_active = 1'b0;
        win_end = 1'b0;
        gsel = 2'h0;
        mix = 24'h0;
        sx = 32'h0;
        a = 16'h0;
        ch = 0;
        n = s;
        n.sync1 = {rld_sat_lo, rld_sat_hi, dc_comp_lo, dc_comp_hi};
        n.sync2 = s.sync1;
        n.sync3 = s.sync2;
        // Comparator bit accepted once stages two and three agree
        for (int b = 0; b < 14; b++) begin
            if (s.sync2[b] == s.sync3[b]) begin
                n.comp[b] = s.sync3[b]; // RL22
            end
        end

        // Factory defaults, captured once after reset release
        if (!s.nvm_done) begin
            for (int g = 0; g < 3; g++) begin
                n.coef[g] = nvm_coef[g]; // RL1
            end
            n.coef[3] = {3{`ELO_COEF_UNITY}}; // RL1
            n.nvm_done = 1'b1;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `ELO_ADDR_FRONT: n.front = reg_wdata[4:0];
                `ELO_ADDR_CTRL: begin
                    n.dc_en = reg_wdata[`ELO_CTRL_DCEN]; // RL4
                    n.ac_en = reg_wdata[`ELO_CTRL_ACEN]; // RL4
                    n.dc_cur = reg_wdata[`ELO_CTRL_DCCUR_MSB:
                                         `ELO_CTRL_DCCUR_LSB]; // RL8
                    n.ac_amp = reg_wdata[`ELO_CTRL_AMP_MSB:
                                         `ELO_CTRL_AMP_LSB]; // RL12
                    n.pol = reg_wdata[`ELO_CTRL_POL_MSB:
                                      `ELO_CTRL_POL_LSB]; // RL12
                end
                `ELO_ADDR_UTH: n.uth = reg_wdata;
                `ELO_ADDR_LTH: n.lth = reg_wdata;
                default: begin
                    if (reg_addr >= `ELO_ADDR_GAIN0 &&
                        reg_addr <= `ELO_ADDR_GAIN2) begin
                        ch = int'(reg_addr - `ELO_ADDR_GAIN0);
                        gsel = reg_wdata[`ELO_GAIN_IDX_MSB:
                                         `ELO_GAIN_IDX_LSB];
                        n.coef[gsel][ch] =
                            reg_wdata[`ELO_GAIN_COEF_MSB:0]; // RL2
                    end
                end
            endcase
        end
        // A zero current code is not a legal step
        if (n.dc_cur == 3'h0) begin
            n.dc_cur = `ELO_DCCUR_RESET; // RL8
        end

        // Register reads, one cycle later; unmapped reads zero
        n.rd_valid = reg_rd;
        if (reg_rd) begin
            n.rdata = 24'h0;
            gsel = s.front[`ELO_FRONT_GAIN_MSB:`ELO_FRONT_GAIN_LSB];
            unique case (reg_addr)
                `ELO_ADDR_FRONT: n.rdata = {19'h0, s.front};
                `ELO_ADDR_CTRL: n.rdata = {s.pol, s.ac_amp, 11'h0,
                                           s.dc_cur, s.ac_en, s.dc_en};
                `ELO_ADDR_UTH: n.rdata = s.uth;
                `ELO_ADDR_LTH: n.rdata = s.lth;
                `ELO_ADDR_STATUS: n.rdata = {11'h0, elec}; // RL6
                `ELO_ADDR_DCSTAT: n.rdata = {16'h0,
                    s.dc_en ? s.comp[13:12] : 2'h0, elec.dc_off}; // RL10
                default: begin
                    if (reg_addr >= `ELO_ADDR_GAIN0 &&
                        reg_addr <= `ELO_ADDR_GAIN2) begin
                        ch = int'(reg_addr - `ELO_ADDR_GAIN0);
                        n.rdata = {gsel, 10'h0, s.coef[gsel][ch]};
                    end else if (reg_addr >= `ELO_ADDR_AMP0 &&
                                 reg_addr < `ELO_ADDR_AMP4) begin
                        ch = int'(reg_addr - `ELO_ADDR_AMP0);
                        n.rdata = {8'h0, s.amp[ch]}; // RL17
                    end
                end
            endcase
        end

        // Carrier generator and excitation polarity
        ac_active = s.ac_en & ~s.front[`ELO_FRONT_CALDAC]; // RL4 RL19
        n.phase = s.phase + `ELO_PHASE_INC; // RL11
        n.drive = ac_active ? ({6{s.phase[31]}} ^ s.pol) : 6'h00; // RL12

        // I/Q demodulation over a fixed window
        win_end = (s.win_cnt == 24'(AC_WINDOW_CYC - 1));
        n.win_cnt = win_end ? 24'h0 : s.win_cnt + 24'h1;
        if (ac_in_valid && ac_active) begin
            for (int c = 0; c < 4; c++) begin // RL13
                sx = {{16{ac_in[c][15]}}, ac_in[c]};
                n.acc_i[c] = s.phase[31] ? s.acc_i[c] + sx
                                         : s.acc_i[c] - sx; // RL14
                n.acc_q[c] = (s.phase[31] ^ s.phase[30])
                             ? s.acc_q[c] + sx : s.acc_q[c] - sx; // RL14
            end
        end
        if (win_end) begin
            for (int c = 0; c < 4; c++) begin
                a = amp_of(s.acc_i[c], s.acc_q[c]);
                // Half-step low-pass keeps detection under the limit
                n.amp[c] = 16'((17'(s.amp[c]) + 17'(a)) >> 1); // RL14 RL18
                n.acc_i[c] = 32'h0;
                n.acc_q[c] = 32'h0;
                n.ac_off[c] = ac_active &&
                    (n.amp[c] > s.uth[`ELO_TH_AC_MSB:0] ||
                     n.amp[c] < s.lth[`ELO_TH_AC_MSB:0]); // RL15 RL16
            end
        end
        if (!ac_active) begin
            n.ac_off = 4'h0; // RL19 RL22
        end

        // ECG path: carrier notch, range check, gain correction
        n.ecg_valid = ecg_in_valid;
        if (ecg_in_valid) begin
            gsel = s.front[`ELO_FRONT_GAIN_MSB:`ELO_FRONT_GAIN_LSB];
            for (int c = 0; c < 3; c++) begin
                n.ecg_prev[c] = ecg_in[c];
                mix = 24'((25'($signed(ecg_in[c])) +
                           25'($signed(s.ecg_prev[c]))) >>> 1); // RL11
                n.ecg_out[c] = gain_fix(mix, s.coef[gsel][c]); // RL3
                n.oor[c] = ($signed(ecg_in[c][23:16]) >
                            $signed(s.uth[`ELO_TH_ADC_MSB:`ELO_TH_ADC_LSB]))
                        || ($signed(ecg_in[c][23:16]) <
                            $signed(s.lth[`ELO_TH_ADC_MSB:`ELO_TH_ADC_LSB]));
                // RL20 RL22
            end
        end

        n.shield_on = s.front[`ELO_FRONT_SHIELD] &
                      ~s.front[`ELO_FRONT_RESPCAP]; // RL21
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s <= '0;
            s.dc_cur <= `ELO_DCCUR_RESET;
            s.uth <= `ELO_UTH_RESET;
            s.lth <= `ELO_LTH_RESET;
            s.coef <= {12{`ELO_COEF_UNITY}};
        end else begin
            s <= n;
        end
    end

    // Frame flags registered so the outputs come from flip-flops
    elo_header_t hdr_q;
    elo_electrodes_t elec_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hdr_q <= '0;
            elec_q <= '0;
        end else begin
            hdr_q <= hdr; // RL5
            elec_q <= elec; // RL6
        end
    end

    assign reg_rdata = s.rdata;
    assign reg_rdata_valid = s.rd_valid;
    assign ecg_out = s.ecg_out;
    assign ecg_out_valid = s.ecg_valid;
    assign frame_header = hdr_q;
    assign frame_electrodes = elec_q;
    assign ac_drive = s.drive;
    assign ac_drive_amp = s.ac_amp;
    assign dc_current_code = s.dc_cur;
    assign dc_inject_en = s.dc_en;
    assign shield_drive_en = s.shield_on;
endmodule : elo_monitor
`default_nettype wire

/* elo_chk.sv */
// Port checker for the electrode lead-off monitor
`default_nettype none
module elo_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [5:0] dc_comp_hi,
    input wire logic [5:0] dc_comp_lo,
    input wire logic reg_rd,
    input wire logic reg_rdata_valid,
    input wire logic ecg_in_valid,
    input wire logic ecg_out_valid,
    input wire elo_pkg::elo_header_t frame_header,
    input wire elo_pkg::elo_electrodes_t frame_electrodes,
    input wire logic [2:0] dc_current_code,
    input wire logic dc_inject_en
);
    import elo_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_rd_answer: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read not answered next cycle");
    a_rd_cause: assert property (reg_rdata_valid |-> $past(reg_rd))
        else $error("read data valid without a read");
    a_ecg_answer: assert property (ecg_in_valid |=> ecg_out_valid)
        else $error("ecg sample not answered next cycle");
    a_ecg_cause: assert property (ecg_out_valid |-> $past(ecg_in_valid))
        else $error("ecg output without a sample");
    a_header_lead: assert property ((|frame_electrodes.ac_off
        || |frame_electrodes.dc_off) |-> frame_header.lead_off)
        else $error("header lead-off bit missing");
    a_header_range: assert property (frame_header.out_of_range
        == |frame_electrodes.out_of_range)
        else $error("header out-of-range bit wrong");
    a_dc_gated: assert property (!dc_inject_en [*3]
        |-> frame_electrodes.dc_off == 6'h00)
        else $error("dc flag while dc detection off");
    a_dc_first: assert property ((dc_inject_en && dc_comp_hi[0]) [*6]
        |-> frame_electrodes.dc_off[0])
        else $error("dc flag of first input missing");
    a_dc_last: assert property ((dc_inject_en && dc_comp_lo[5]) [*6]
        |-> frame_electrodes.dc_off[5])
        else $error("dc flag of common-mode input missing");
    a_dc_clear: assert property ((!dc_comp_hi[0] && !dc_comp_lo[0]) [*6]
        |-> !frame_electrodes.dc_off[0])
        else $error("dc flag stuck after condition gone");
    a_cur_legal: assert property (dc_current_code != 3'h0)
        else $error("dc current code zero");
    c_lead: cover property (frame_header.lead_off);
    c_range: cover property (frame_header.out_of_range);
    c_ac: cover property (|frame_electrodes.ac_off);
endmodule : elo_chk
bind elo_monitor elo_chk i_elo_chk (.clk_sys, .reset_n, .dc_comp_hi,
    .dc_comp_lo, .reg_rd, .reg_rdata_valid, .ecg_in_valid, .ecg_out_valid,
    .frame_header, .frame_electrodes, .dc_current_code, .dc_inject_en);
`default_nettype wire

/* elo_electrodes.sv */
// Behavioural model of patient electrodes and cabling
`default_nettype none
module elo_electrodes (
    input wire logic clk_sys,
    input wire logic [5:0] off_mask,
    input wire logic [5:0] short_mask,
    input wire logic rl_off,
    input wire logic [5:0] ac_drive,
    input wire logic dc_inject_en,
    output logic [5:0] dc_comp_hi,
    output logic [5:0] dc_comp_lo,
    output logic rld_sat_lo,
    output logic [3:0][15:0] ac_in,
    output logic ac_in_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AC_MAP [4] = '{1, 2, 0, 5};
    // Open pin floats high only while current is injected
    assign dc_comp_hi = off_mask & {6{dc_inject_en}};
    assign dc_comp_lo = short_mask;
    assign rld_sat_lo = rl_off;
    always @(posedge clk_sys) begin
        ac_in_valid <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            // Open electrode sees the large divider swing
            ac_in[k] <= (off_mask[AC_MAP[k]] ? 16'd4000 : 16'd8)
                * (ac_drive[AC_MAP[k]] ? 16'd1 : 16'hffff);
        end
    end
endmodule : elo_electrodes
`default_nettype wire

/* electrode_lead_off_monitor_tb.sv */
// Self-checking testbench for the electrode lead-off monitor
`include "elo_regs.svh"
`default_nettype none
module electrode_lead_off_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import elo_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, rl_off, rld_sat_lo, reg_wr, reg_rd;
    logic ecg_in_valid, ac_in_valid, reg_rdata_valid, ecg_out_valid;
    logic dc_inject_en, shield_drive_en;
    logic [5:0] off_mask, short_mask, reg_addr, ac_drive, dc_comp_hi, dc_comp_lo;
    logic [3:0][2:0][11:0] cf;
    logic [2:0][23:0] ecg_in, ecg_out, prev;
    logic [3:0][15:0] ac_in;
    logic [23:0] reg_wdata, reg_rdata;
    logic [1:0] ac_drive_amp, gsel;
    logic [2:0] dc_current_code;
    elo_header_t frame_header;
    elo_electrodes_t frame_electrodes;
    int errors = 0, checks_done = 0, cycles = 0, seed = 32'h7760e8dd;
    logic [29:0] rq[$];
    logic [2:0][23:0] eq[$];
    localparam logic W = 1'b1, R = 1'b0;
    always #4 clk_sys = ~clk_sys;
    elo_monitor #(.AC_WINDOW_CYC(64)) i_elo_monitor (.clk_sys, .reset_n,
        .dc_comp_hi, .dc_comp_lo, .rld_sat_hi(1'b0), .rld_sat_lo,
        .nvm_coef(cf[2:0]), .ecg_in, .ecg_in_valid, .ac_in, .ac_in_valid,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rdata_valid,
        .ecg_out, .ecg_out_valid, .frame_header, .frame_electrodes, .ac_drive,
        .ac_drive_amp, .dc_current_code, .dc_inject_en, .shield_drive_en);
    elo_electrodes i_elo_electrodes (.clk_sys, .off_mask, .short_mask,
        .rl_off, .ac_drive, .dc_inject_en, .dc_comp_hi, .dc_comp_lo,
        .rld_sat_lo, .ac_in, .ac_in_valid);
    task automatic chk(input string n, input logic [23:0] e, logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    // One register access; a read notes its expected word
    task automatic acc(input logic w, logic [5:0] a, logic [23:0] d);
        if (!w) rq.push_back({a, d});
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : acc
    task automatic send(input logic [23:0] hi);
        logic [2:0][23:0] x, e;
        longint s;
        for (int c = 0; c < 3; c++) begin
            x[c] = (24'($random(seed)) & 24'h0ffffe) | (c == 1 ? hi : 24'h0);
            s = (longint'(x[c]) + longint'(prev[c])) / 2;
            e[c] = 24'((s * longint'(cf[gsel][c])) >> 11);
            prev[c] = x[c];
        end
        eq.push_back(e);
        @(posedge clk_sys);
        ecg_in <= x;
        ecg_in_valid <= 1'b1;
        @(posedge clk_sys);
        ecg_in_valid <= 1'b0;
    endtask : send
    always @(negedge clk_sys) begin
        logic [29:0] r;
        logic [2:0][23:0] e;
        if (reg_rdata_valid === 1'b1) begin
            r = rq.pop_front();
            chk($sformatf("reg %h", r[29:24]), r[23:0], reg_rdata);
        end
        if (ecg_out_valid === 1'b1) begin
            e = eq.pop_front();
            for (int c = 0; c < 3; c++) chk("ecg_out", e[c], ecg_out[c]);
        end
        cycles++;
        if (cycles > 20000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        logic [23:0] d;
        logic [5:0] m;
        {off_mask, short_mask, rl_off, reg_addr, reg_wr, reg_rd} = '0;
        {reg_wdata, ecg_in, ecg_in_valid, prev} = '0;
        for (int g = 0; g < 4; g++)
            for (int c = 0; c < 3; c++)
                cf[g][c] = g == 3 ? 12'h800 : 12'h400 + 12'(g * 256 + c * 16);
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        acc(R, `ELO_ADDR_CTRL, 24'h000004);
        acc(R, `ELO_ADDR_UTH, `ELO_UTH_RESET);
        acc(R, `ELO_ADDR_LTH, `ELO_LTH_RESET);
        acc(R, `ELO_ADDR_AMP4, 24'h0);
        acc(R, 6'h3f, 24'h0);
        for (int k = 0; k < 8; k++) begin
            d = {6'($random(seed)), 2'(k), 11'h0, 3'(k), 2'b00};
            acc(W, `ELO_ADDR_CTRL, d);
            d[4:2] = k == 0 ? 3'h1 : 3'(k);
            acc(R, `ELO_ADDR_CTRL, d);
            @(negedge clk_sys);
            chk("dc_current_code", 24'(d[4:2]), 24'(dc_current_code));
            chk("ac_drive_amp", 24'(k[1:0]), 24'(ac_drive_amp));
        end
        acc(W, `ELO_ADDR_CTRL, 24'h00001d);
        rl_off <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            m = 6'($random(seed));
            off_mask <= k[0] ? m : 6'h0;
            short_mask <= k[0] ? 6'h0 : m;
            repeat (6) @(posedge clk_sys);
            acc(R, `ELO_ADDR_DCSTAT, {16'h0, 2'b10, m});
            acc(R, `ELO_ADDR_STATUS, {18'h0, m});
            @(negedge clk_sys);
            chk("lead_off", 24'h1, 24'(frame_header.lead_off));
            chk("dc_inject_en", 24'h1, 24'(dc_inject_en));
        end
        acc(W, `ELO_ADDR_CTRL, 24'h000004);
        repeat (6) @(posedge clk_sys);
        acc(R, `ELO_ADDR_DCSTAT, 24'h0);
        {rl_off, short_mask} <= '0;
        acc(W, `ELO_ADDR_UTH, 24'h7f0064);
        acc(W, `ELO_ADDR_LTH, 24'h800000);
        off_mask <= 6'h0a;
        acc(W, `ELO_ADDR_CTRL, {6'($random(seed)), 16'h0, 2'b10});
        repeat (1000) @(posedge clk_sys);
        acc(R, `ELO_ADDR_STATUS, 24'h000040);
        acc(W, `ELO_ADDR_LTH, 24'h807fff);
        repeat (200) @(posedge clk_sys);
        acc(R, `ELO_ADDR_STATUS, 24'h0003c0);
        acc(W, `ELO_ADDR_FRONT, 24'h000019);
        repeat (10) @(posedge clk_sys);
        acc(R, `ELO_ADDR_STATUS, 24'h0);
        acc(W, `ELO_ADDR_CTRL, 24'h000004);
        for (int s = 0; s < 4; s++) begin
            acc(W, `ELO_ADDR_FRONT, 24'(s << 1));
            // Enable follows the front register one edge later
            @(posedge clk_sys);
            @(negedge clk_sys);
            chk("shield_drive_en", 24'(s == 1), 24'(shield_drive_en));
        end
        for (int g = 0; g < 4; g++) begin
            gsel = 2'(g);
            acc(W, `ELO_ADDR_FRONT, {19'h0, 2'(g), 3'h0});
            send(24'h0);
            send(24'h0);
            acc(R, `ELO_ADDR_GAIN0, {2'(g), 10'h0, cf[g][0]});
        end
        cf[3][1] = 12'h900;
        acc(W, `ELO_ADDR_GAIN0 + 6'h1, {12'hc00, cf[3][1]});
        send(24'h0);
        acc(R, `ELO_ADDR_GAIN0 + 6'h1, {12'hc00, cf[3][1]});
        acc(W, `ELO_ADDR_UTH, 24'h200064);
        send(24'h300000);
        acc(R, `ELO_ADDR_STATUS, 24'h000800);
        send(24'h0);
        acc(R, `ELO_ADDR_STATUS, 24'h0);
        repeat (4) @(posedge clk_sys);
        conclude();
    end
endmodule : electrode_lead_off_monitor_tb
`default_nettype wire
